/* hdl/pwr_state_pkg.sv */
/*
 power state controller package: offsets, reset values, counts, state enum.
 assumes a 40 MHz standby clock.
*/
package pwr_state_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int CLK_HZ = 40000000;
   localparam int SHORT_PRESS_S = 4;
   localparam int FORCE_OFF_S = 6;
   localparam int DEBOUNCE_US = 10000;
   localparam int SHORT_PRESS_CYC = SHORT_PRESS_S * CLK_HZ;
   localparam int FORCE_OFF_CYC = FORCE_OFF_S * CLK_HZ;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1000000));

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] EVENT_OFF = 8'h08;
   localparam logic [7:0] MASK_OFF = 8'h0C;
   localparam logic [7:0] CMD_OFF = 8'h10;

   // ctrl fields
   localparam int CTRL_BTN_SOFTOFF = 0;
   localparam int CTRL_USB_DEEP_EN = 1;
   localparam int CTRL_LAST_OVR_EN = 2;
   localparam int CTRL_LAST_OVR_ON = 3;
   localparam int CTRL_DEEPEST = 4;
   localparam int CTRL_ALARM_EN = 5;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

   // cmd codes written by os
   localparam logic [1:0] CMD_S3 = 2'h1;
   localparam logic [1:0] CMD_S4 = 2'h2;
   localparam logic [1:0] CMD_S5 = 2'h3;

   // event bit positions
   localparam int EV_BTN = 0;
   localparam int EV_RTC = 1;
   localparam int EV_LAN = 2;
   localparam int EV_USB = 3;
   localparam int EV_PCIE = 4;
   localparam int EV_IR = 5;
   localparam int EV_FORCE = 6;
   localparam int EV_ACRET = 7;
   localparam int EV_W = 8;
   localparam logic [EV_W-1:0] MASK_RST = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_G3,
      ST_S0,
      ST_S3,
      ST_S4,
      ST_S5
   } pwr_state_e;

endpackage : pwr_state_pkg

/* hdl/system_power_state_wake_control.sv */
/*
 power state and wake controller with axi4-lite register slave.
 assumes async pins come from outside the clock domain; acPresent low is
 mechanical off; sys_clk and rst run from standby power.
*/
`timescale 1ns/100ps

module system_power_state_wake_control #(
   parameter int FORCE_CYC = pwr_state_pkg::FORCE_OFF_CYC,
   parameter int SHORT_CYC = pwr_state_pkg::SHORT_PRESS_CYC,
   parameter int DEB_CYC = pwr_state_pkg::DEBOUNCE_CYC
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic pwrSwitchN,
   input wire logic acPresent,
   input wire logic rtcAlarm,
   input wire logic lanWake,
   input wire logic usbActivity,
   input wire logic pcieWakeN,
   input wire logic consumer_infrared_input,
   input wire logic radioActivity,
   output logic mainPowerEn,
   output logic coldBoot,
   output logic displayOn,
   output logic ledGreen,
   output logic ledAmber,
   output logic standbyLed,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int EW = pwr_state_pkg::EV_W;
   localparam int CW = pwr_state_pkg::CTRL_W;

   initial
   begin
      if (SHORT_CYC < 1 || FORCE_CYC <= SHORT_CYC || DEB_CYC < 1)
         $error("bad press timing parameters");
   end

   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int NS = 7;
   logic [NS-1:0] syncA_ff;
   logic [NS-1:0] syncB_ff;
   wire [NS-1:0] rawIn = {~pwrSwitchN, acPresent, rtcAlarm, lanWake, usbActivity, ~pcieWakeN,
      consumer_infrared_input};

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         syncA_ff <= '0;
         syncB_ff <= '0;
      end
      else
      begin
         syncA_ff <= rawIn;
         syncB_ff <= syncA_ff;
      end
   end

   wire btnSync = syncB_ff[6];
   wire acOk = syncB_ff[5];
   wire rtcS = syncB_ff[4];
   wire lanS = syncB_ff[3];
   wire usbS = syncB_ff[2];
   wire pcieS = syncB_ff[1];
   wire irS = syncB_ff[0];
   wire radioIgnored = radioActivity & 1'b0;
   // ****************************************
   // switch debounce and hold timer
   // ****************************************
   logic btnDeb_ff;
   logic [31:0] debCnt_ff;
   logic [31:0] holdCnt_ff;
   logic forceDone_ff;
   wire debFlip = (btnSync != btnDeb_ff) && (debCnt_ff >= 32'(DEB_CYC - 1));
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         btnDeb_ff <= 1'b0;
         debCnt_ff <= 32'h0000_0000;
      end
      else
      begin
         debCnt_ff <= (btnSync == btnDeb_ff || debFlip) ? 32'h0000_0000 : debCnt_ff + 32'h0000_0001;
         if (debFlip)
            btnDeb_ff <= btnSync;
      end
   end
   wire btnRelease = debFlip && btnDeb_ff;
   wire shortPress = btnRelease && !forceDone_ff && (holdCnt_ff < 32'(SHORT_CYC));
   wire forceHit = btnDeb_ff && !forceDone_ff && (holdCnt_ff == 32'(FORCE_CYC - 1));
   always_ff @(posedge sys_clk)
   begin
      if (rst || !btnDeb_ff)
      begin
         holdCnt_ff <= 32'h0000_0000;
         forceDone_ff <= 1'b0;
      end
      else
      begin
         if (!forceDone_ff)
            holdCnt_ff <= holdCnt_ff + 32'h0000_0001;
         if (forceHit)
            forceDone_ff <= 1'b1;
      end
   end
   // ****************************************
   // wake sources
   // ****************************************
   logic [2:0] prev_ff;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         prev_ff <= 3'h0;
      else
         prev_ff <= {rtcS, lanS, irS};
   end
   wire rtcRise = rtcS & ~prev_ff[2];
   wire lanRise = lanS & ~prev_ff[1];
   wire irRise = irS & ~prev_ff[0];
   pwr_state_pkg::pwr_state_e state_ff;
   pwr_state_pkg::pwr_state_e nxt_state;
   logic [CW-1:0] ctrl_ff;
   logic [EW-1:0] evt_ff;
   logic [EW-1:0] mask_ff;
   logic afterG3_ff;
   logic lastOn_ff;
   logic coldBoot_ff;
   logic displayOn_ff;
   logic [1:0] osCmd;
   logic osCmdValid;
   wire inS3 = state_ff == pwr_state_pkg::ST_S3;
   wire inS4 = state_ff == pwr_state_pkg::ST_S4;
   wire inS5 = state_ff == pwr_state_pkg::ST_S5;
   wire sleeping = inS3 | inS4 | inS5;
   wire deepest = ctrl_ff[pwr_state_pkg::CTRL_DEEPEST] & (inS4 | inS5);
   wire btnWake = sleeping & shortPress;
   wire rtcWake = sleeping & rtcRise & ctrl_ff[pwr_state_pkg::CTRL_ALARM_EN];
   wire lanWakeOk = sleeping & lanRise;
   wire usbWake = usbS & !afterG3_ff & (inS3 | ((inS4 | inS5) & ctrl_ff[pwr_state_pkg::CTRL_USB_DEEP_EN]
      & !deepest));
   wire pcieWake = pcieS & (inS3 | inS4);
   wire irWake = irRise & sleeping & !deepest;
   wire anyWake = btnWake | rtcWake | lanWakeOk | usbWake | pcieWake | irWake | radioIgnored;
   wire onlyRtc = rtcWake & !(btnWake | lanWakeOk | usbWake | pcieWake | irWake);
   wire restoreOn = ctrl_ff[pwr_state_pkg::CTRL_LAST_OVR_EN] ? ctrl_ff[pwr_state_pkg::CTRL_LAST_OVR_ON] : lastOn_ff;
   // ****************************************
   // state machine
   // ****************************************
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         pwr_state_pkg::ST_G3:
            if (acOk)
               nxt_state = restoreOn ? pwr_state_pkg::ST_S0 : pwr_state_pkg::ST_S5;
         pwr_state_pkg::ST_S0:
            if (forceHit)
               nxt_state = pwr_state_pkg::ST_S5;
            else if (shortPress)
               nxt_state = ctrl_ff[pwr_state_pkg::CTRL_BTN_SOFTOFF] ? pwr_state_pkg::ST_S5 : pwr_state_pkg::ST_S3;
            else if (osCmdValid && osCmd == pwr_state_pkg::CMD_S3)
               nxt_state = pwr_state_pkg::ST_S3;
            else if (osCmdValid && osCmd == pwr_state_pkg::CMD_S4)
               nxt_state = pwr_state_pkg::ST_S4;
            else if (osCmdValid && osCmd == pwr_state_pkg::CMD_S5)
               nxt_state = pwr_state_pkg::ST_S5;
         pwr_state_pkg::ST_S3, pwr_state_pkg::ST_S4:
            if (forceHit)
               nxt_state = pwr_state_pkg::ST_S5;
            else if (anyWake)
               nxt_state = pwr_state_pkg::ST_S0;
         pwr_state_pkg::ST_S5:
            if (anyWake)
               nxt_state = pwr_state_pkg::ST_S0;
      endcase
      if (!acOk)
         nxt_state = pwr_state_pkg::ST_G3;
   end
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_ff <= pwr_state_pkg::ST_G3;
         afterG3_ff <= 1'b1;
         lastOn_ff <= 1'b0;
         coldBoot_ff <= 1'b0;
         displayOn_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (state_ff == pwr_state_pkg::ST_G3)
            afterG3_ff <= 1'b1;
         else if (nxt_state == pwr_state_pkg::ST_S0)
            afterG3_ff <= 1'b0;
         if (acOk && state_ff != pwr_state_pkg::ST_G3)
            lastOn_ff <= (state_ff == pwr_state_pkg::ST_S0);
         // cold boot from s5 or g3
         coldBoot_ff <= (nxt_state == pwr_state_pkg::ST_S0) && (inS5 || state_ff == pwr_state_pkg::ST_G3);
         if (nxt_state != pwr_state_pkg::ST_S0)
            displayOn_ff <= 1'b0;
         else if (state_ff != pwr_state_pkg::ST_S0)
            displayOn_ff <= !onlyRtc;
         else if (anyWake || shortPress)
            displayOn_ff <= 1'b1;
      end
   end

   assign mainPowerEn = state_ff == pwr_state_pkg::ST_S0;
   assign ledGreen = state_ff == pwr_state_pkg::ST_S0;
   assign ledAmber = inS3;
   assign standbyLed = acOk;
   assign coldBoot = coldBoot_ff;
   assign displayOn = displayOn_ff;

   // ****************************************
   // axi4-lite slave
   // ****************************************
   logic awHeld_ff;
   logic wHeld_ff;
   logic [7:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   logic bvalid_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [1:0] bresp_ff;
   assign s_axi_awready = !awHeld_ff && !bvalid_ff;
   assign s_axi_wready = !wHeld_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   wire wrGo = awHeld_ff && wHeld_ff && !bvalid_ff;
   wire rdGo = s_axi_arvalid && s_axi_arready;
   wire wrCtrl = wrGo && awAddr_ff == pwr_state_pkg::CTRL_OFF && wStrb_ff[0];
   wire wrEvt = wrGo && awAddr_ff == pwr_state_pkg::EVENT_OFF && wStrb_ff[0];
   wire wrMask = wrGo && awAddr_ff == pwr_state_pkg::MASK_OFF && wStrb_ff[0];
   assign osCmdValid = wrGo && awAddr_ff == pwr_state_pkg::CMD_OFF && wStrb_ff[0];
   assign osCmd = wData_ff[1:0];
   wire wrHit = awAddr_ff == pwr_state_pkg::CTRL_OFF || awAddr_ff == pwr_state_pkg::EVENT_OFF
      || awAddr_ff == pwr_state_pkg::MASK_OFF || awAddr_ff == pwr_state_pkg::CMD_OFF
      || awAddr_ff == pwr_state_pkg::STATUS_OFF;
   wire rdHit = s_axi_araddr == pwr_state_pkg::CTRL_OFF || s_axi_araddr == pwr_state_pkg::STATUS_OFF
      || s_axi_araddr == pwr_state_pkg::EVENT_OFF || s_axi_araddr == pwr_state_pkg::MASK_OFF
      || s_axi_araddr == pwr_state_pkg::CMD_OFF;
   wire [31:0] statusWord = {24'h00_0000, afterG3_ff, lastOn_ff, displayOn_ff, acOk, 1'b0, 3'(state_ff)};
   wire [31:0] rdMux = (s_axi_araddr == pwr_state_pkg::CTRL_OFF) ? {26'h000_0000, ctrl_ff}
      : (s_axi_araddr == pwr_state_pkg::STATUS_OFF) ? statusWord
      : (s_axi_araddr == pwr_state_pkg::EVENT_OFF) ? {24'h00_0000, evt_ff}
      : (s_axi_araddr == pwr_state_pkg::MASK_OFF) ? {24'h00_0000, mask_ff}
      : 32'h0000_0000;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= pwr_state_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (wrGo)
         begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wrHit ? pwr_state_pkg::RESP_OKAY : pwr_state_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= pwr_state_pkg::RESP_OKAY;
      end
      else if (rdGo)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rdMux;
         rresp_ff <= rdHit ? pwr_state_pkg::RESP_OKAY : pwr_state_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_ff <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // ****************************************
   // control, events and interrupt
   // ****************************************
   wire [EW-1:0] evSet = {(state_ff == pwr_state_pkg::ST_G3) && acOk, forceHit, irWake, pcieWake, usbWake,
      lanWakeOk, rtcWake, btnWake};

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctrl_ff <= pwr_state_pkg::CTRL_RST;
         mask_ff <= pwr_state_pkg::MASK_RST;
         evt_ff <= '0;
      end
      else
      begin
         if (wrCtrl)
            ctrl_ff <= wData_ff[CW-1:0];
         if (wrMask)
            mask_ff <= wData_ff[EW-1:0];
         // set wins over clear
         evt_ff <= (evt_ff & ~(wrEvt ? wData_ff[EW-1:0] : '0)) | evSet;
      end
   end

   assign irq = |(evt_ff & mask_ff);

endmodule : system_power_state_wake_control

/* verif/system_power_state_wake_control_checker.sv */
/*
 port checks on the power state controller.
 assumes the bind passes on the shortened hold counts.
*/
`timescale 1ns/100ps
module system_power_state_wake_control_checker #(
   parameter int FORCE_CYC = 400,
   parameter int DEB_CYC = 4
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic pwrSwitchN,
   input wire logic acPresent,
   input wire logic mainPowerEn,
   input wire logic coldBoot,
   input wire logic ledGreen,
   input wire logic ledAmber,
   input wire logic standbyLed,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ****************************************
   // switch hold counter
   // ****************************************
   logic [15:0] holdCnt_ff;
   logic [15:0] nxt_holdCnt;
   assign nxt_holdCnt = pwrSwitchN ? 16'h0000 : holdCnt_ff + {15'h0000, holdCnt_ff != 16'hffff};
   always_ff @(posedge sys_clk)
      holdCnt_ff <= rst ? 16'h0000 : nxt_holdCnt;

   // ****************************************
   // properties
   // ****************************************
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   property p_led;
      (mainPowerEn == ledGreen) && !(ledAmber && mainPowerEn);
   endproperty
   property p_cold;
      coldBoot |=> !coldBoot && mainPowerEn;
   endproperty
   property p_std_on;
      $rose(acPresent) |-> ##[1:4] standbyLed;
   endproperty
   property p_std_off;
      $fell(acPresent) |-> ##[1:4] !standbyLed;
   endproperty
   property p_force;
      holdCnt_ff == 16'(FORCE_CYC + DEB_CYC + 16) |-> !mainPowerEn;
   endproperty
   property p_hold;
      !pwrSwitchN [*8] |-> !$rose(mainPowerEn);
   endproperty
   property p_bresp;
      s_wr_take |-> ##[1:2] s_axi_bvalid;
   endproperty
   property p_rresp;
      s_rd_take |=> s_axi_rvalid;
   endproperty
   property p_ar_low;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty

   a_led: assert property (p_led) else $error("led colour disagrees with state");
   a_cold: assert property (p_cold) else $error("cold boot pulse wrong");
   a_std_on: assert property (p_std_on) else $error("standby led not lit");
   a_std_off: assert property (p_std_off) else $error("standby led stays lit");
   a_force: assert property (p_force) else $error("no forced off after long hold");
   a_hold: assert property (p_hold) else $error("power on while switch held");
   a_bresp: assert property (p_bresp) else $error("write response late");
   a_rresp: assert property (p_rresp) else $error("read response late");
   a_ar_low: assert property (p_ar_low) else $error("read address taken during response");
endmodule : system_power_state_wake_control_checker

bind system_power_state_wake_control system_power_state_wake_control_checker #(
   .FORCE_CYC(FORCE_CYC),
   .DEB_CYC(DEB_CYC)
) chk_u (.sys_clk(sys_clk), .rst(rst), .pwrSwitchN(pwrSwitchN), .acPresent(acPresent), .mainPowerEn(mainPowerEn),
   .coldBoot(coldBoot), .ledGreen(ledGreen), .ledAmber(ledAmber), .standbyLed(standbyLed),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

/* verif/wake_source_model.sv */
/*
 far side of the controller: front switch, ac feed and wake sources.
 assumes tasks are called just after a rising clock edge.
*/
`timescale 1ns/100ps
module wake_source_model(
   input wire logic sys_clk,
   output logic pwrSwitchN,
   output logic acPresent,
   output logic rtcAlarm,
   output logic lanWake,
   output logic usbActivity,
   output logic pcieWakeN,
   output logic consumer_infrared_input,
   output logic radioActivity
);
   logic [5:0] srcLvl = 6'h00;
   assign rtcAlarm = srcLvl[0];
   assign lanWake = srcLvl[1];
   assign usbActivity = srcLvl[2];
   assign pcieWakeN = ~srcLvl[3];
   assign consumer_infrared_input = srcLvl[4];
   assign radioActivity = srcLvl[5];
   initial
   begin
      pwrSwitchN = 1'b1;
      acPresent = 1'b1;
   end

   task automatic press(input int n);
      @(posedge sys_clk);
      pwrSwitchN <= 1'b0;
      repeat (n) @(posedge sys_clk);
      pwrSwitchN <= 1'b1;
      repeat (20) @(posedge sys_clk);
   endtask : press

   task automatic wake(input int k);
      @(posedge sys_clk);
      srcLvl[k] <= 1'b1;
      repeat (12) @(posedge sys_clk);
      srcLvl[k] <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask : wake

   task automatic ac(input logic v);
      @(posedge sys_clk);
      acPresent <= v;
      repeat (20) @(posedge sys_clk);
   endtask : ac
endmodule : wake_source_model

/* verif/system_power_state_wake_control_tb.sv */
/*
 bench for the power state controller: axi master, expectation queues.
 assumes shortened hold counts and the partner model on the wake pins.
*/
`timescale 1ns/100ps
module system_power_state_wake_control_tb;
   localparam logic [7:0] CTRL = pwr_state_pkg::CTRL_OFF;
   localparam logic [7:0] EVT = pwr_state_pkg::EVENT_OFF;
   localparam logic [7:0] MSK = pwr_state_pkg::MASK_OFF;
   localparam logic [7:0] CMD = pwr_state_pkg::CMD_OFF;
   typedef struct {logic [33:0] v; logic [33:0] m;} exp_s;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic pwrSwitchN, acPresent, rtcAlarm, lanWake, usbActivity, pcieWakeN;
   logic consumer_infrared_input, radioActivity;
   logic mainPowerEn, coldBoot, displayOn, ledGreen, ledAmber, standbyLed, irq;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = '0;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic coldSeen = 1'b0;
   logic [31:0] rnd;
   int n_errors = 0;
   int check_count = 0;
   exp_s rq[$];
   logic [1:0] bq[$];

   always #12.5 sys_clk = ~sys_clk;

   system_power_state_wake_control #(.FORCE_CYC(400), .SHORT_CYC(200), .DEB_CYC(4)) dut_u (
      .sys_clk, .rst, .pwrSwitchN, .acPresent, .rtcAlarm, .lanWake, .usbActivity, .pcieWakeN,
      .consumer_infrared_input, .radioActivity, .mainPowerEn, .coldBoot, .displayOn, .ledGreen,
      .ledAmber, .standbyLed, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   wake_source_model model_u (.sys_clk(sys_clk), .pwrSwitchN(pwrSwitchN), .acPresent(acPresent),
      .rtcAlarm(rtcAlarm), .lanWake(lanWake), .usbActivity(usbActivity), .pcieWakeN(pcieWakeN),
      .consumer_infrared_input(consumer_infrared_input), .radioActivity(radioActivity));

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      check_count++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   always @(posedge sys_clk)
   begin
      if (coldBoot === 1'b1)
         coldSeen <= 1'b1;
      if (s_axi_rvalid && s_axi_rready)
      begin
         chk({s_axi_rresp, s_axi_rdata} & rq[0].m, rq[0].v);
         void'(rq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         chk(34'(s_axi_bresp), 34'(bq[0]));
         void'(bq.pop_front());
      end
   end

   // ****************************************
   // bus master
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      @(posedge sys_clk);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
      @(posedge sys_clk);
      rq.push_back('{e, m});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic st(input pwr_state_pkg::pwr_state_e s);
      rd(pwr_state_pkg::STATUS_OFF, {31'h0000_0000, s}, 34'h3_0000_0007);
   endtask : st

   task automatic ev(input logic [7:0] b);
      rd(EVT, {26'h000_0000, b}, 34'h3_0000_00ff);
   endtask : ev

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      void'($urandom(32'h226a));
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk(34'(standbyLed), 34'h1);
      st(pwr_state_pkg::ST_S5);
      wr(MSK, 32'h0000_00ff);
      model_u.press(50);
      st(pwr_state_pkg::ST_S0);
      chk(34'(coldSeen), 34'h1);
      chk(34'(irq), 34'h1);
      ev(8'h81);
      wr(EVT, 32'h0000_00ff);
      ev(8'h00);
      chk(34'(irq), 34'h0);
      $display("test switch power on");
      coldSeen <= 1'b0;
      model_u.press(50);
      st(pwr_state_pkg::ST_S3);
      chk(34'({ledAmber, mainPowerEn}), 34'h2);
      model_u.wake(2);
      st(pwr_state_pkg::ST_S0);
      chk(34'(coldSeen), 34'h0);
      wr(CMD, 32'(pwr_state_pkg::CMD_S4));
      model_u.wake(3);
      st(pwr_state_pkg::ST_S0);
      wr(CMD, 32'(pwr_state_pkg::CMD_S5));
      model_u.wake(3);
      st(pwr_state_pkg::ST_S5);
      model_u.wake(5);
      st(pwr_state_pkg::ST_S5);
      model_u.wake(4);
      st(pwr_state_pkg::ST_S0);
      $display("test wake sources");
      wr(CTRL, 32'h0000_0002);
      wr(CMD, 32'(pwr_state_pkg::CMD_S4));
      model_u.wake(2);
      st(pwr_state_pkg::ST_S0);
      wr(CTRL, 32'h0000_0000);
      wr(CMD, 32'(pwr_state_pkg::CMD_S4));
      model_u.wake(2);
      st(pwr_state_pkg::ST_S4);
      model_u.press(50);
      st(pwr_state_pkg::ST_S0);
      wr(EVT, 32'h0000_00ff);
      model_u.press(460);
      st(pwr_state_pkg::ST_S5);
      ev(8'h40);
      $display("test usb and force off");
      wr(CTRL, 32'h0000_0020);
      model_u.wake(0);
      st(pwr_state_pkg::ST_S0);
      chk(34'(displayOn), 34'h0);
      wr(CMD, 32'(pwr_state_pkg::CMD_S5));
      wr(CTRL, 32'h0000_0010);
      model_u.wake(4);
      st(pwr_state_pkg::ST_S5);
      $display("test alarm and deepest sleep");
      wr(CTRL, 32'h0000_0002);
      model_u.ac(1'b0);
      st(pwr_state_pkg::ST_G3);
      chk(34'(standbyLed), 34'h0);
      model_u.ac(1'b1);
      st(pwr_state_pkg::ST_S5);
      model_u.wake(2);
      st(pwr_state_pkg::ST_S5);
      model_u.wake(1);
      st(pwr_state_pkg::ST_S0);
      model_u.ac(1'b0);
      model_u.ac(1'b1);
      st(pwr_state_pkg::ST_S0);
      wr(CMD, 32'(pwr_state_pkg::CMD_S5));
      wr(CTRL, 32'h0000_000c);
      model_u.ac(1'b0);
      model_u.ac(1'b1);
      st(pwr_state_pkg::ST_S0);
      wr(CTRL, 32'h0000_0004);
      model_u.ac(1'b0);
      model_u.ac(1'b1);
      st(pwr_state_pkg::ST_S5);
      $display("test ac return");
      wr(CTRL, 32'h0000_0001);
      model_u.press(50);
      st(pwr_state_pkg::ST_S0);
      model_u.press(50);
      st(pwr_state_pkg::ST_S5);
      model_u.wake(1);
      wr(CMD, 32'(pwr_state_pkg::CMD_S3));
      st(pwr_state_pkg::ST_S3);
      $display("test os settings");
      rd(8'h20, {pwr_state_pkg::RESP_SLVERR, 32'h0000_0000}, 34'h3_ffff_ffff);
      wr(8'h20, 32'h0000_0001, pwr_state_pkg::RESP_SLVERR);
      rnd = $urandom;
      wr(MSK, rnd);
      rd(MSK, {26'h000_0000, rnd[7:0]}, 34'h3_ffff_ffff);
      $display("test register bus");
      repeat (4) @(posedge sys_clk);
      wrap_up();
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      wrap_up();
   end
endmodule : system_power_state_wake_control_tb
